/* File: rtl/stm56_consts.svh */
// register offsets, field positions and reset values of the system timer
`ifndef STM56_CONSTS_SVH
`define STM56_CONSTS_SVH
`define STM56_CNT_W 56
`define STM56_CAP_W 24
`define STM56_OFF_VIEW0 8'h00
`define STM56_OFF_VIEW5 8'h14
`define STM56_OFF_CAP 8'h18
`define STM56_OFF_CLC 8'h1C
`define STM56_OFF_CMP0 8'h20
`define STM56_OFF_CMP1 8'h24
`define STM56_OFF_CMPCFG 8'h28
`define STM56_OFF_STAT 8'h2C
`define STM56_OFF_MASK 8'h30
`define STM56_OFF_ARST 8'h34
`define STM56_VIEW_STEP 6'h04
`define STM56_VIEW5_SHIFT 6'h18
`define STM56_VIEW5_IDX 3'h5
`define STM56_CLC_DIS_BIT 0
`define STM56_CLC_DIS_STAT_BIT 1
`define STM56_CLC_SUSP_BIT 3
`define STM56_CLC_RATE_BIT 8
`define STM56_CFG_SIZE_POS 0
`define STM56_CFG_START_POS 8
`define STM56_CFG_CH_STRIDE 16
`define STM56_RST_CFG_SIZE 5'h1F
`define STM56_RST_CFG_START 5'h00
`define STM56_RST_RATE 1'h0
`endif

/* File: rtl/stm56_pkg.sv */
// types shared by the system timer
package stm56_pkg;
   typedef struct packed {
      logic [4:0] start;
      logic [4:0] size;
   } stm56_cmpcfg_s;

   typedef struct packed {
      logic [55:0] cnt;
      logic [23:0] cap;
      logic pre;
      logic dis;
      logic susp_en;
      logic rate;
      logic arst_dis;
      logic [1:0][31:0] cmp;
      stm56_cmpcfg_s [1:0] cfg;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [1:0] match_q;
      logic [31:0] rdata;
   } stm56_state_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } stm56_bus_s;
endpackage

/* File: rtl/stm56_timer.sv */
// free-running 56-bit system timer with views, capture and compares
//
// Function
// - A 56-bit counter adds one on each timer count tick while enabled.
// - Six read-only 32-bit views each show a different counter slice.
// - The count tick comes from the system clock, /2 after reset or /1.
// - Watchdog, software and power-on resets clear and restart the timer.
// - Application reset clears the timer only while its disable bit is 0.
// - Writes to the counter views are ignored.
// - Disable or debug suspend stops counting; registers stay readable.
// - Reading any counter view copies the upper counter bits to capture.
// - Two compare values each can raise an interrupt on a match.
// - Each compare looks at a chosen slice of the counter.
// - Unimplemented bits read as zero.
//
// The address map and the plain strobed port are this design's own decisions.
`include "stm56_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module stm56_timer (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic wdt_reset_i,
   input wire logic sw_reset_i,
   input wire logic app_reset_i,
   input wire logic debug_suspend_i,
   input wire stm56_pkg::stm56_bus_s bus_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   output logic [1:0] match_o
);

   stm56_pkg::stm56_state_s s;
   stm56_pkg::stm56_state_s next_s;
   stm56_pkg::stm56_state_s rst_s;
   logic run;
   logic tick;
   logic sys_clr;
   logic app_clr;
   logic is_view;
   logic [2:0] view_idx;
   logic [5:0] view_sh;
   logic [1:0] match;
   logic [1:0] match_rise;

   always_comb begin
      rst_s = '0;
      rst_s.rate = `STM56_RST_RATE;
      for (int i = 0; i < 2; i++) begin
         rst_s.cfg[i].size = `STM56_RST_CFG_SIZE;
         rst_s.cfg[i].start = `STM56_RST_CFG_START;
      end
   end

   // resets from the watchdog and software paths clear everything
   assign sys_clr = wdt_reset_i | sw_reset_i;
   // the disable bit itself belongs to reset control, so it survives
   assign app_clr = app_reset_i & ~s.arst_dis;

   assign run = ~s.dis & ~(s.susp_en & debug_suspend_i);
   // rate 0 counts every second clock, the reset default
   assign tick = run & (s.rate | s.pre);

   assign is_view = (bus_i.addr <= `STM56_OFF_VIEW5)
      && (bus_i.addr[1:0] == 2'h0);
   assign view_idx = bus_i.addr[4:2];
   assign view_sh = (view_idx == `STM56_VIEW5_IDX) ? `STM56_VIEW5_SHIFT
      : 6'(view_idx * `STM56_VIEW_STEP);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_cmp
         logic [55:0] slice;
         logic [31:0] sel_mask;
         assign slice = s.cnt >> s.cfg[g].start;
         assign sel_mask = 32'hFFFFFFFF >> (5'h1F - s.cfg[g].size);
         assign match[g] = ((slice[31:0] ^ s.cmp[g]) & sel_mask) == '0;
         // only a new match raises the event, a frozen one does not repeat
         assign match_rise[g] = match[g] & ~s.match_q[g];
      end
   endgenerate

   always_comb begin
      next_s = s;
      next_s.rdata = '0;
      next_s.match_q = match;
      if (run) begin
         next_s.pre = ~s.pre;
      end
      if (tick) begin
         next_s.cnt = s.cnt + 56'h1;
      end
      // set wins over a same-cycle write-one-to-clear
      if (bus_i.wr && bus_i.addr == `STM56_OFF_STAT) begin
         next_s.stat = s.stat & ~bus_i.wdata[1:0];
      end
      next_s.stat = next_s.stat | match_rise;
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            `STM56_OFF_CLC: begin
               next_s.dis = bus_i.wdata[`STM56_CLC_DIS_BIT];
               next_s.susp_en = bus_i.wdata[`STM56_CLC_SUSP_BIT];
               next_s.rate = bus_i.wdata[`STM56_CLC_RATE_BIT];
            end
            `STM56_OFF_CMP0: next_s.cmp[0] = bus_i.wdata;
            `STM56_OFF_CMP1: next_s.cmp[1] = bus_i.wdata;
            `STM56_OFF_CMPCFG: begin
               for (int i = 0; i < 2; i++) begin
                  next_s.cfg[i].size = bus_i.wdata[i*`STM56_CFG_CH_STRIDE
                     + `STM56_CFG_SIZE_POS +: 5];
                  next_s.cfg[i].start = bus_i.wdata[i*`STM56_CFG_CH_STRIDE
                     + `STM56_CFG_START_POS +: 5];
               end
            end
            `STM56_OFF_MASK: next_s.mask = bus_i.wdata[1:0];
            `STM56_OFF_ARST: next_s.arst_dis = bus_i.wdata[0];
            // counter views and capture take no writes
            default: ;
         endcase
      end
      if (bus_i.rd) begin
         if (is_view) begin
            next_s.rdata = 32'(s.cnt >> view_sh);
            next_s.cap = s.cnt[55:32];
         end else begin
            unique case (bus_i.addr)
               `STM56_OFF_CAP: next_s.rdata = {8'h00, s.cap};
               `STM56_OFF_CLC: begin
                  next_s.rdata[`STM56_CLC_DIS_BIT] = s.dis;
                  next_s.rdata[`STM56_CLC_DIS_STAT_BIT] = s.dis;
                  next_s.rdata[`STM56_CLC_SUSP_BIT] = s.susp_en;
                  next_s.rdata[`STM56_CLC_RATE_BIT] = s.rate;
               end
               `STM56_OFF_CMP0: next_s.rdata = s.cmp[0];
               `STM56_OFF_CMP1: next_s.rdata = s.cmp[1];
               `STM56_OFF_CMPCFG: begin
                  for (int i = 0; i < 2; i++) begin
                     next_s.rdata[i*`STM56_CFG_CH_STRIDE
                        + `STM56_CFG_SIZE_POS +: 5] = s.cfg[i].size;
                     next_s.rdata[i*`STM56_CFG_CH_STRIDE
                        + `STM56_CFG_START_POS +: 5] = s.cfg[i].start;
                  end
               end
               `STM56_OFF_STAT: next_s.rdata = {30'h0, s.stat};
               `STM56_OFF_MASK: next_s.rdata = {30'h0, s.mask};
               `STM56_OFF_ARST: next_s.rdata = {31'h0, s.arst_dis};
               // unmapped reads return zero
               default: next_s.rdata = '0;
            endcase
         end
      end
      if (sys_clr) begin
         next_s = rst_s;
      end else if (app_clr) begin
         next_s = rst_s;
         next_s.arst_dis = s.arst_dis;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
         s.rate <= `STM56_RST_RATE;
         s.cfg[0].size <= `STM56_RST_CFG_SIZE;
         s.cfg[1].size <= `STM56_RST_CFG_SIZE;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign rdata_o = s.rdata;
   assign irq_o = |(s.stat & s.mask);
   assign match_o = s.match_q;

   // helper flag for checks spanning cycles, high from the first clock after reset
   logic chk_valid;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chk_valid <= 1'b0;
      end else begin
         chk_valid <= 1'b1;
      end
   end

   a_count_step: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && tick && !sys_clr && !app_clr)
      |=> s.cnt == $past(s.cnt) + 56'h1)
      else $error("counter did not step on a tick");

   a_count_wrap: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && tick && !sys_clr && !app_clr && (&s.cnt))
      |=> s.cnt == '0)
      else $error("counter did not wrap to zero");

   a_half_rate: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && run && !s.rate && !sys_clr && !app_clr)
      ##1 (ce_i && run && !s.rate && !sys_clr && !app_clr)
      |=> s.cnt == $past(s.cnt, 2) + 56'h1)
      else $error("reset rate does not count every second clock");

   a_frozen_hold: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && !run && !sys_clr && !app_clr) |=> $stable(s.cnt))
      else $error("counter moved while stopped");

   a_capture_view: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.rd && is_view && !sys_clr && !app_clr)
      |=> s.cap == $past(s.cnt[55:32])
         && rdata_o == 32'($past(s.cnt) >> $past(view_sh)))
      else $error("capture or view data wrong after a view read");

   a_view_no_write: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.wr && is_view && !tick && !sys_clr && !app_clr)
      |=> $stable(s.cnt) && $stable(s.cap))
      else $error("write to a counter view changed the timer");

   a_sys_clear: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && sys_clr) |=> s.cnt == '0 && !s.dis && s.stat == '0
         ##1 (ce_i && !sys_clr && !app_clr)[*2] ##1 s.cnt == 56'h1)
      else $error("timer not cleared and restarted by reset");

   a_app_kept: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && app_reset_i && s.arst_dis && !sys_clr && tick)
      |=> s.cnt == $past(s.cnt) + 56'h1)
      else $error("application reset touched a protected timer");

   a_match_flag: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && chk_valid && match_rise[0] && s.mask[0] && !bus_i.wr
         && !sys_clr && !app_clr)
      |=> s.stat[0] && irq_o)
      else $error("compare match did not raise the interrupt");

   a_unmapped_zero: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.rd && bus_i.addr > `STM56_OFF_ARST)
      |=> rdata_o == '0)
      else $error("unmapped read returned nonzero data");

   // a low enable must hold every bit of state, read data included
   a_ce_freeze: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      !ce_i |=> $stable(s))
      else $error("state moved while the clock enable was low");

   a_rdata_idle: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && !bus_i.rd) |=> rdata_o == '0)
      else $error("read data not zero outside a read answer");

   a_view0_slice: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.rd && bus_i.addr == `STM56_OFF_VIEW0
         && !sys_clr && !app_clr)
      |=> rdata_o == $past(s.cnt[31:0]))
      else $error("lowest view does not show the low counter bits");

   a_view5_slice: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.rd && bus_i.addr == `STM56_OFF_VIEW5
         && !sys_clr && !app_clr)
      |=> rdata_o == $past(s.cnt[55:24]))
      else $error("top view does not show the high counter bits");

   a_cap_read: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.rd && bus_i.addr == `STM56_OFF_CAP
         && !sys_clr && !app_clr)
      |=> rdata_o == {8'h00, $past(s.cap)})
      else $error("capture read returned wrong data");

   // capture must not drift between the view read and its own read
   a_cap_hold: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && !(bus_i.rd && is_view) && !sys_clr && !app_clr)
      |=> $stable(s.cap))
      else $error("capture changed without a view read");

   a_cmp0_write: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.wr && bus_i.addr == `STM56_OFF_CMP0
         && !sys_clr && !app_clr)
      |=> s.cmp[0] == $past(bus_i.wdata))
      else $error("first compare value not taken");

   a_cmp1_write: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.wr && bus_i.addr == `STM56_OFF_CMP1
         && !sys_clr && !app_clr)
      |=> s.cmp[1] == $past(bus_i.wdata))
      else $error("second compare value not taken");

   a_stat_clear: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.wr && bus_i.addr == `STM56_OFF_STAT
         && match_rise == 2'h0 && !sys_clr && !app_clr)
      |=> s.stat == ($past(s.stat) & ~$past(bus_i.wdata[1:0])))
      else $error("status write-one-to-clear misbehaved");

   a_set_wins: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && match_rise[1] && !sys_clr && !app_clr)
      |=> s.stat[1])
      else $error("second compare event did not set its status");

   a_app_clear: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && app_reset_i && !s.arst_dis && !sys_clr)
      |=> s.cnt == '0 && !s.arst_dis)
      else $error("application reset did not clear the timer");

   a_wdt_clear: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && wdt_reset_i)
      |=> s.cnt == '0 && s.cap == '0 && s.mask == '0 && !s.rate)
      else $error("watchdog reset did not clear the timer");

   a_cfg_write: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.wr && bus_i.addr == `STM56_OFF_CMPCFG
         && !sys_clr && !app_clr)
      |=> s.cfg[1].start == $past(bus_i.wdata[`STM56_CFG_CH_STRIDE
         + `STM56_CFG_START_POS +: 5]))
      else $error("compare slice start not taken");

   a_rate_write: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && bus_i.wr && bus_i.addr == `STM56_OFF_CLC
         && !sys_clr && !app_clr)
      |=> s.rate == $past(bus_i.wdata[`STM56_CLC_RATE_BIT]))
      else $error("count rate select not taken");

   // checked apart from run so a broken run term still shows
   a_susp_stop: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && s.susp_en && debug_suspend_i && !sys_clr && !app_clr)
      |=> $stable(s.cnt))
      else $error("counter moved in debug suspend");

   a_dis_stop: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      (ce_i && s.dis && !sys_clr && !app_clr)
      |=> $stable(s.cnt))
      else $error("counter moved while disabled");

endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the 56-bit system timer
`include "stm56_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk_i;
   logic rst_b_i;
   logic [2:0] rq;
   logic dbg;
   logic ce;
   stm56_pkg::stm56_bus_s bus;
   logic [31:0] rdata;
   logic irq;
   logic [1:0] match;
   int n_mismatch = 0;
   int compares = 0;
   logic [31:0] v;
   logic [31:0] w;

   stm56_timer uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .wdt_reset_i(rq[0]), .sw_reset_i(rq[1]), .app_reset_i(rq[2]),
      .debug_suspend_i(dbg), .bus_i(bus), .rdata_o(rdata), .irq_o(irq),
      .match_o(match));

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus.wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic pulse(input int i);
      @(posedge mclk_i);
      rq[i] <= 1'b1;
      @(posedge mclk_i);
      rq[i] <= 1'b0;
   endtask

   task automatic wait_irq(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_i);
         #1;
         if (irq === 1'b1) break;
      end
   endtask

   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #500000;
      n_mismatch++;
      conclude();
   end

   initial begin
      rst_b_i = 1'b0;
      bus = '0;
      rq = 3'h0;
      dbg = 1'b0;
      ce = 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(`STM56_OFF_CLC, v);
      chk("clc", v, 32'h0);
      rd(`STM56_OFF_CMPCFG, v);
      chk("cmpcfg", v, 32'h001F001F);
      rd(8'h40, v);
      chk("unmapped", v, 32'h0);
      $display("test reset done");
      wr(`STM56_OFF_CLC, 32'h100);
      rd(`STM56_OFF_VIEW0, v);
      rd(`STM56_OFF_VIEW0, w);
      chk("step", w - v, 32'h2);
      wr(`STM56_OFF_VIEW0, 32'hFFFFFFFF);
      rd(`STM56_OFF_VIEW0, v);
      chk("view write", {31'h0, v < 32'h100}, 32'h1);
      rd(8'h04, v);
      rd(`STM56_OFF_VIEW0, w);
      chk("view1", v, (w - 32'h2) >> 4);
      rd(`STM56_OFF_VIEW5, v);
      chk("view5", v, 32'h0);
      rd(`STM56_OFF_CAP, v);
      chk("capture", v, 32'h0);
      $display("test views done");
      wr(`STM56_OFF_CLC, 32'h101);
      rd(`STM56_OFF_VIEW0, v);
      repeat (5) @(posedge mclk_i);
      rd(`STM56_OFF_VIEW0, w);
      chk("disabled", w, v);
      rd(`STM56_OFF_CLC, v);
      chk("clc dis", v, 32'h103);
      @(posedge mclk_i);
      #1;
      chk("rdata idle", rdata, 32'h0);
      wr(`STM56_OFF_CLC, 32'h108);
      @(posedge mclk_i);
      dbg <= 1'b1;
      rd(`STM56_OFF_VIEW0, v);
      rd(`STM56_OFF_VIEW0, w);
      chk("suspended", w, v);
      @(posedge mclk_i);
      dbg <= 1'b0;
      rd(`STM56_OFF_VIEW0, v);
      rd(`STM56_OFF_VIEW0, w);
      chk("resumed", w - v, 32'h2);
      // four edges with the enable low: three counts instead of seven
      rd(`STM56_OFF_VIEW0, v);
      @(posedge mclk_i);
      ce <= 1'b0;
      repeat (4) @(posedge mclk_i);
      ce <= 1'b1;
      rd(`STM56_OFF_VIEW0, w);
      chk("ce freeze", w - v, 32'h3);
      $display("test clock control done");
      wr(`STM56_OFF_STAT, 32'h3);
      wr(`STM56_OFF_MASK, 32'h1);
      rd(`STM56_OFF_VIEW0, v);
      wr(`STM56_OFF_CMP0, v + 32'd40);
      wait_irq(100);
      chk("irq0", {31'h0, irq}, 32'h1);
      rd(`STM56_OFF_STAT, v);
      chk("stat0", v, 32'h1);
      wr(`STM56_OFF_STAT, 32'h1);
      #1;
      chk("irq clr", {31'h0, irq}, 32'h0);
      // ch1 looks at counter bits 7:4 only
      wr(`STM56_OFF_CMPCFG, 32'h0403001F);
      wr(`STM56_OFF_MASK, 32'h2);
      wait_irq(300);
      chk("irq1", {31'h0, irq}, 32'h1);
      chk("match", {30'h0, match}, 32'h2);
      rd(`STM56_OFF_STAT, v);
      chk("stat1", v, 32'h2);
      wr(`STM56_OFF_MASK, 32'h0);
      $display("test compare done");
      wr(`STM56_OFF_ARST, 32'h1);
      pulse(2);
      rd(`STM56_OFF_VIEW0, v);
      chk("app kept", {31'h0, v > 32'h100}, 32'h1);
      wr(`STM56_OFF_ARST, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(`STM56_OFF_CLC, 32'h100);
         repeat (20) @(posedge mclk_i);
         pulse(i);
         rd(`STM56_OFF_VIEW0, v);
         chk("cleared", {31'h0, v < 32'h10}, 32'h1);
         rd(`STM56_OFF_CLC, v);
         chk("clc cleared", v, 32'h0);
      end
      $display("test resets done");
      conclude();
   end
endmodule
`default_nettype wire
